// file: sensor_interrupt_service_logic_test.sv
`timescale 1ns/1ps
`default_nettype none
module sensor_interrupt_service_logic_test
    import sisl_pkg::*;
;
    logic          ref_clk;  // Core clock.
    logic          resetn;   // Active low reset.
    logic [12:0]   pls;      // Pulses: hardware resets, events, soft reset, accum, done.
    logic          wake;     // Wake state level.
    logic          push;     // Sample push strobe.
    logic [4:0]    cond;     // Motion conditions.
    sisl_reg_req_t req;      // Register request.
    logic [7:0]    rdata;    // Register read data.
    sisl_pin_drv_t pa;       // First pin drive.
    sisl_pin_drv_t pb;       // Second pin drive.
    wire logic     line_a;   // First line level.
    wire logic     line_b;   // Second line level.
    int            fails;    // Mismatches seen.
    int            checks;   // Comparisons made.
    // Reset rows: address in the upper byte, expected value below.
    logic [15:0]   rows [11] = '{16'h0400, 16'h0600, 16'h0A00, 16'h0D00, 16'h1400,
        16'h2D00, 16'h2E10, 16'h2F00, 16'h3100, 16'h3300, 16'h5000};

    ////////////////////////////////////////////////////////////////////////////
    // A short latch period keeps the timeout case quick.
    sisl_irq_ctrl #(
        .TEMP_LATCH_CYCLES(8)
    ) DUT (
        .ref_clk            (ref_clk),
        .resetn             (resetn),
        .soft_reset_command (pls[2]),
        .reg_req            (req),
        .reg_rdata          (rdata),
        .wake_state         (wake),
        .sample_push        (push),
        .z_accum_start      (pls[1]),
        .sample_done        (pls[0]),
        .motion_event       (pls[7:3]),
        .motion_cond        (cond),
        .motion_hw_reset    (pls[12:8]),
        .irq_pin_a          (pa),
        .irq_pin_b          (pb)
    );
    sisl_host_model HOST (
        .irq_pin_a (pa),
        .irq_pin_b (pb),
        .line_a    (line_a),
        .line_b    (line_b)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Free running 100 MHz clock.
    initial begin
        ref_clk = 1'h0;
        forever #5 ref_clk = ~ref_clk;
    end
    // Every drive lands 1 ns after a rising edge, clear of sampling.
    task automatic step();
        @(posedge ref_clk);
        #1;
    endtask
    // Compares one byte and records a mismatch.
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // A write is held for exactly one taking edge.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        step();
        req = '{1'h1, 1'h0, a, d};
        step();
        req = '0;
    endtask
    // Read data is settled just after the taking edge.
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        step();
        req = '{1'h0, 1'h1, a, 8'h00};
        step();
        req = '0;
        chk8(rdata, exp);
    endtask
    // One-cycle pulse on the chosen event inputs.
    task automatic pulse(input logic [12:0] v);
        step();
        pls = v;
        step();
        pls = '0;
    endtask
    // Pushes n samples back to back.
    task automatic fill(input int n);
        step();
        push = 1'h1;
        repeat (n) step();
        push = 1'h0;
    endtask
    // Prints the verdict and ends the run.
    task automatic finish_test();
        if (fails == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // A hang counts as a mismatch.
    initial begin
        #100000;
        fails++;
        finish_test();
    end

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence.
    initial begin
        {resetn, pls, wake, push, cond, req} = '0;
        repeat (20) @(posedge ref_clk);
        #1;
        resetn = 1'h1;
        // Unmapped writes must be dropped.
        wr(8'h50, 8'hFF);
        foreach (rows[i]) rd(rows[i][15:8], rows[i][7:0]);
        chk8({7'h00, line_a}, 8'h01);
        wr(8'h06, 8'h80);
        wr(8'h2D, 8'h26);
        wr(8'h2E, 8'h04);
        wake = 1'h1;
        pulse(8'h01);
        step();
        chk8({7'h00, line_a}, 8'h00);
        rd(8'h14, 8'h80);
        // Threshold boundary: one below, then exactly at it.
        fill(3);
        rd(8'h0A, 8'h00);
        fill(1);
        rd(8'h0A, 8'h04);
        rd(8'h2F, 8'h04);
        chk8({7'h00, line_b}, 8'h00);
        wr(8'h04, 8'h00);
        rd(8'h14, 8'h00);
        rd(8'h2F, 8'h00);
        chk8({6'h00, line_a, line_b}, 8'h03);
        fill(28);
        rd(8'h0A, 8'h06);
        chk8({7'h00, line_b}, 8'h00);
        // Bitmask clearing.
        wr(8'h31, 8'h40);
        pulse(8'h01);
        wr(8'h04, 8'hFF);
        rd(8'h14, 8'h80);
        wr(8'h14, 8'h01);
        rd(8'h14, 8'h80);
        wr(8'h14, 8'h20);
        rd(8'h2F, 8'h00);
        wr(8'h14, 8'h80);
        rd(8'h14, 8'h00);
        // Pop then push re-raises full for the routing cases.
        rd(8'h0D, 8'h00);
        fill(1);
        wr(8'h31, 8'h50);
        step();
        chk8({6'h00, line_a, line_b}, 8'h01);
        wr(8'h31, 8'h40);
        wr(8'h2D, 8'h2E);
        step();
        chk8({6'h00, line_a, line_b}, 8'h01);
        wr(8'h2D, 8'h26);
        // Temporary latch times out; buffer flags stay.
        wr(8'h31, 8'h01);
        pulse(8'h01);
        rd(8'h14, 8'h80);
        repeat (10) step();
        rd(8'h14, 8'h00);
        chk8({7'h00, line_b}, 8'h00);
        // Auto-clear of sample and motion flags.
        wr(8'h31, 8'h03);
        wr(8'h06, 8'h81);
        pulse(8'h01);
        rd(8'h14, 8'h80);
        pulse(8'h02);
        rd(8'h14, 8'h00);
        cond = 5'h01;
        pulse(8'h08);
        rd(8'h14, 8'h01);
        cond = 5'h00;
        rd(8'h14, 8'h00);
        // A hardware reset clears a motion flag while its condition holds.
        cond = 5'h01;
        pulse(8'h08);
        pulse(13'h0100);
        rd(8'h14, 8'h00);
        cond = 5'h00;
        // First pin push-pull active high; second stays open drain.
        wr(8'h31, 8'h00);
        wr(8'h33, 8'h0C);
        pulse(8'h01);
        step();
        chk8({4'h0, pa.o, pa.oe, pb.o, pb.oe}, 8'h0D);
        // Both pins push-pull active high, only the buffer request pending.
        wr(8'h33, 8'hCC);
        wr(8'h31, 8'h50);
        wr(8'h14, 8'h80);
        step();
        chk8({4'h0, pa.o, pa.oe, pb.o, pb.oe}, 8'h0D);
        wr(8'h31, 8'h40);
        wr(8'h2D, 8'h2E);
        step();
        chk8({4'h0, pa.o, pa.oe, pb.o, pb.oe}, 8'h0D);
        pulse(8'h04);
        rd(8'h2E, 8'h10);
        rd(8'h2F, 8'h00);
        // The empty flag latches when the last sample is read out.
        wr(8'h2D, 8'h21);
        fill(1);
        rd(8'h0D, 8'h00);
        rd(8'h0A, 8'h01);
        rd(8'h2F, 8'h01);
        finish_test();
    end
endmodule
`default_nettype wire

// file: sisl_buf_level.sv
`timescale 1ns/1ps
`default_nettype none
`include "sisl_map.svh"
module sisl_buf_level
    import sisl_pkg::*;
(
    input  wire logic          ref_clk,
    input  wire logic          resetn,
    input  wire logic          soft_clr,
    input  wire logic          push,
    input  wire logic          pop,
    input  wire logic [7:0]    thr,
    output var  sisl_buf_lvl_t lvl
);
    // Number of samples held.
    logic [5:0] cnt_r;
    logic [5:0] cnt_nxt;

    // Pushes stop at full and pops at empty, so the count never wraps.
    always_comb begin
        cnt_nxt = cnt_r;
        if (push && (cnt_r != `SISL_BUF_DEPTH) && !(pop && (cnt_r != 6'h00))) begin
            cnt_nxt = cnt_r + 6'h01;
        end else if (pop && (cnt_r != 6'h00) && !(push && (cnt_r != `SISL_BUF_DEPTH))) begin
            cnt_nxt = cnt_r - 6'h01;
        end
    end

    // Count register; a soft reset empties the buffer.
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            cnt_r <= 6'h00;
        end else if (soft_clr) begin
            cnt_r <= 6'h00;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    // Conditions follow the new count and the threshold, so they move on a push, a pop or a threshold write.
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            lvl <= 3'h1;
        end else if (soft_clr) begin
            lvl <= 3'h1;
        end else begin
            lvl.empty <= (cnt_nxt == 6'h00);
            lvl.full  <= (cnt_nxt == `SISL_BUF_DEPTH);
            lvl.level <= ({2'h0, cnt_nxt} >= thr);
        end
    end
endmodule
`default_nettype wire

// file: sisl_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// Host side of the two interrupt lines, as the microprocessor sees them.
module sisl_host_model
    import sisl_pkg::*;
(
    input  wire sisl_pin_drv_t irq_pin_a,
    input  wire sisl_pin_drv_t irq_pin_b,
    output wire logic          line_a,
    output wire logic          line_b
);
    // Each line has a board pull-up, so a released pin reads high.
    // A floating line would leave the level to the simulator.
    assign line_a = irq_pin_a.oe ? irq_pin_a.o : 1'h1;
    assign line_b = irq_pin_b.oe ? irq_pin_b.o : 1'h1;
endmodule
`default_nettype wire

// file: sisl_irq_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "sisl_map.svh"
// Overview of operation
// - Full flag in status bit one, gated
// - Full flag clears on any reset
// - Full interrupt enabled by control bit one
// - Level flag in status bit two, gated
// - Level flag resets; threshold defaults sixteen
// - Level interrupt when count reaches threshold
// - Level interrupt enabled by control bit two
// - Full interrupt at thirty-two stored samples
// - Empty interrupt at zero; data reads pop
// - Global mode: any clear write clears all
// - Global mode ignores the written data
// - Bitmask mode: only status register clears
// - Bitmask mode: ones clear selected flags
// - Bitmask bit five clears buffer flags
// - Buffer flags latched, cleared only by writes or reset
// - Temporary latch: timeout or write clears
// - Auto mode: sample flag clears at accumulation
// - Auto mode: motion flag follows its condition
// - Tilt flag set by detector event
// - Default: motion to pin a, buffer b
// - Per-pin drive mode and polarity register
// - Swap bit exchanges the two requests
// - Merge bit folds everything onto request a
module sisl_irq_ctrl
    import sisl_pkg::*;
#(
    parameter int unsigned TEMP_LATCH_CYCLES = `SISL_TEMP_LATCH_NS / `SISL_CLK_NS
) (
    input  wire logic          ref_clk,
    input  wire logic          resetn,
    input  wire logic          soft_reset_command,
    input  wire sisl_reg_req_t reg_req,
    output var  logic [7:0]    reg_rdata,
    input  wire logic          wake_state,
    input  wire logic          sample_push,
    input  wire logic          z_accum_start,
    input  wire logic          sample_done,
    input  wire logic [4:0]    motion_event,
    input  wire logic [4:0]    motion_cond,
    input  wire logic [4:0]    motion_hw_reset,
    output var  sisl_pin_drv_t irq_pin_a,
    output var  sisl_pin_drv_t irq_pin_b
);
    localparam int TLW = $clog2(TEMP_LATCH_CYCLES + 1);

    default clocking dc @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    // Address match, used for every decode.
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction

    // Pin level and enable from request, polarity and drive mode.
    function automatic sisl_pin_drv_t drive(input logic req, input logic pol, input logic pp);
        logic lvl;
        lvl = pol ? req : !req;
        drive.o  = pp ? lvl : 1'b0;
        drive.oe = pp ? 1'b1 : !lvl;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Configuration registers.
    ////////////////////////////////////////////////////////////////////////
    logic [7:0] irq_en_r;      // Sample and motion enables.
    logic [7:0] buf_ctrl_r;    // Buffer enable, its interrupt enables, merge.
    logic [7:0] buf_thr_r;     // Buffer threshold count.
    logic [7:0] mode_ctrl_r;   // Clear mode, swap and interrupt mode.
    logic [7:0] pin_ctrl_r;    // Drive and polarity per pin.
    logic       wr14;          // Write to the status register.
    logic       wr04;          // Write to the status alias.
    logic       bitmask;       // Individual clear mode selected.
    logic       buf_en;        // Buffer enabled.
    logic       merge;         // Requests combined onto request a.
    sisl_irq_mode_t mode;      // Operating mode of sample and motion flags.

    assign wr14    = reg_req.wr && hit(reg_req.addr, `SISL_ADDR_IRQ_STAT);
    assign wr04    = reg_req.wr && hit(reg_req.addr, `SISL_ADDR_CLR_ALIAS);
    assign bitmask = mode_ctrl_r[`SISL_BITMASK_BIT];
    assign buf_en  = buf_ctrl_r[`SISL_BUF_EN_BIT];
    assign merge   = buf_ctrl_r[`SISL_MERGE_BIT];
    assign mode    = sisl_irq_mode_t'(mode_ctrl_r[1:0]);

    // Software writes; a soft reset restores the reset values.
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            irq_en_r    <= `SISL_ZERO8;
            buf_ctrl_r  <= `SISL_ZERO8;
            buf_thr_r   <= `SISL_THR_RESET;
            mode_ctrl_r <= `SISL_ZERO8;
            pin_ctrl_r  <= `SISL_ZERO8;
        end else if (soft_reset_command) begin
            irq_en_r    <= `SISL_ZERO8;
            buf_ctrl_r  <= `SISL_ZERO8;
            buf_thr_r   <= `SISL_THR_RESET;
            mode_ctrl_r <= `SISL_ZERO8;
            pin_ctrl_r  <= `SISL_ZERO8;
        end else if (reg_req.wr) begin
            if (hit(reg_req.addr, `SISL_ADDR_IRQ_EN)) begin
                irq_en_r <= reg_req.wdata;
            end else if (hit(reg_req.addr, `SISL_ADDR_BUF_CTRL)) begin
                buf_ctrl_r <= reg_req.wdata;
            end else if (hit(reg_req.addr, `SISL_ADDR_BUF_THR)) begin
                buf_thr_r <= reg_req.wdata;
            end else if (hit(reg_req.addr, `SISL_ADDR_MODE_CTRL)) begin
                mode_ctrl_r <= reg_req.wdata;
            end else if (hit(reg_req.addr, `SISL_ADDR_PIN_CTRL)) begin
                pin_ctrl_r <= reg_req.wdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Buffer level tracking and buffer flags.
    ////////////////////////////////////////////////////////////////////////
    sisl_buf_lvl_t lvl;        // Current buffer conditions.
    sisl_buf_lvl_t lvl_prev_r; // Conditions one cycle ago, for edges.
    logic [2:0] buf_irq_r;     // Latched buffer flags.
    logic [2:0] buf_set;       // Newly reached, enabled conditions.
    logic       buf_clr;       // Clear of all buffer flags.
    logic       buf_pop;       // Host read of the data register.

    // hardware fills only when awake and enabled.
    // each data read removes a sample while the buffer is enabled.
    assign buf_pop = reg_req.rd && hit(reg_req.addr, `SISL_ADDR_BUF_DATA);

    sisl_buf_level u_level (
        .ref_clk  (ref_clk),
        .resetn   (resetn),
        .soft_clr (soft_reset_command),
        .push     (sample_push && wake_state && buf_en),
        .pop      (buf_pop && buf_en),
        .thr      (buf_thr_r),
        .lvl      (lvl)
    );

    // Edge memory; the buffer starts empty.
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            lvl_prev_r <= 3'h1;
        end else begin
            lvl_prev_r <= lvl;
        end
    end

    // enables come from the buffer control register only.
    // set when the count reaches the threshold.
    // level enable bit.
    // A flag sets on the edge of its condition, so a clear that lands
    // while the condition still holds does not instantly re-fire.
    assign buf_set = lvl & ~lvl_prev_r & buf_ctrl_r[2:0] & {3{buf_en}};

    assign buf_clr = (!bitmask && (wr14 || wr04)) ||
                     (bitmask && wr14 && reg_req.wdata[`SISL_BUF_CLR_BIT]);

    // latched only; no timeout or auto clear reaches these.
    // buffer flags zero after any reset.
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            buf_irq_r <= 3'h0;
        end else if (soft_reset_command) begin
            buf_irq_r <= 3'h0;
        end else begin
            // A new event wins over a clear in the same cycle.
            buf_irq_r <= (buf_irq_r & ~{3{buf_clr}}) | buf_set;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sample and motion flags: bits 4..0 motion, bit 5 sample ready.
    ////////////////////////////////////////////////////////////////////////
    logic [5:0] sm_r;          // Pending sample and motion flags.
    logic [5:0] sm_set;        // Enabled events this cycle.
    logic [5:0] clr_sel;       // Flags cleared by a register write.
    logic [5:0] tmo;           // Temporary latch expiries.
    logic [5:0] auto_clr;      // Auto-clear conditions.
    logic [TLW-1:0] tl_cnt_r [6]; // Temporary latch timers.

    // tilt event from the detector sets bit zero.
    assign sm_set = {sample_done && irq_en_r[`SISL_SAMPLE_BIT], motion_event & irq_en_r[4:0]};

    // global mode clears everything on either address.
    // alias does nothing in bitmask mode.
    // ones select the flags to clear.
    always_comb begin
        clr_sel = 6'h00;
        if (!bitmask && (wr14 || wr04)) begin
            clr_sel = 6'h3F;
        end else if (bitmask && wr14) begin
            clr_sel = {reg_req.wdata[`SISL_SAMPLE_BIT], reg_req.wdata[4:0]};
        end
    end

    // accumulation start ends the sample flag.
    // motion flags drop with their condition or a hardware reset.
    assign auto_clr = (mode == SISL_MODE_AUTO) ?
                      {z_accum_start, ~motion_cond | motion_hw_reset} : 6'h00;

    // per-flag timers, restarted on every set.
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < 6; i++) begin
                tl_cnt_r[i] <= '0;
            end
        end else begin
            for (int i = 0; i < 6; i++) begin
                if (sm_set[i]) begin
                    tl_cnt_r[i] <= TLW'(TEMP_LATCH_CYCLES);
                end else if (clr_sel[i] || soft_reset_command) begin
                    tl_cnt_r[i] <= '0;
                end else if (tl_cnt_r[i] != '0) begin
                    tl_cnt_r[i] <= tl_cnt_r[i] - TLW'(1);
                end
            end
        end
    end

    // Expiry is the last counted cycle, only in temporary latch mode.
    always_comb begin
        for (int i = 0; i < 6; i++) begin
            tmo[i] = (mode == SISL_MODE_TEMP) && (tl_cnt_r[i] == TLW'(1));
        end
    end

    // Set has priority over every clear source except a soft reset.
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            sm_r <= 6'h00;
        end else if (soft_reset_command) begin
            sm_r <= 6'h00;
        end else begin
            sm_r <= (sm_r & ~(clr_sel | tmo | auto_clr)) | sm_set;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Request routing and pins.
    ////////////////////////////////////////////////////////////////////////
    logic sm_any;              // Any sample or motion flag pending.
    logic buf_any;             // Any buffer flag pending.
    logic req_a;               // Internal request a.
    logic req_b;               // Internal request b.
    logic swap;                // Requests swapped between pins.

    assign sm_any  = |sm_r;
    assign buf_any = |buf_irq_r;
    // merge folds buffer into request a and silences b.
    assign req_a   = sm_any || (merge && buf_any);
    assign req_b   = !merge && buf_any;
    assign swap    = mode_ctrl_r[`SISL_SWAP_BIT];

    // default routing, a to pin a, b to pin b.
    // swap moves requests, pin settings stay put.
    // pin asserted while a routed flag is pending.
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            irq_pin_a <= 2'h0;
            irq_pin_b <= 2'h0;
        end else begin
            irq_pin_a <= drive(swap ? req_b : req_a, pin_ctrl_r[`SISL_PIN_A_POL_BIT],
                               pin_ctrl_r[`SISL_PIN_A_PP_BIT]);
            irq_pin_b <= drive(swap ? req_a : req_b, pin_ctrl_r[`SISL_PIN_B_POL_BIT],
                               pin_ctrl_r[`SISL_PIN_B_PP_BIT]);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register reads; reads have no side effect except the data pop.
    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            reg_rdata <= `SISL_ZERO8;
        end else if (reg_req.rd) begin
            if (hit(reg_req.addr, `SISL_ADDR_IRQ_STAT) || hit(reg_req.addr, `SISL_ADDR_CLR_ALIAS)) begin
                reg_rdata <= {sm_r[5], 2'h0, sm_r[4:0]};
            end else if (hit(reg_req.addr, `SISL_ADDR_BUF_STAT)) begin
                // full condition, valid only when enabled.
                // level condition, valid only when enabled.
                reg_rdata <= {5'h00, lvl & {3{buf_en}}};
            end else if (hit(reg_req.addr, `SISL_ADDR_BUF_IRQ)) begin
                reg_rdata <= {5'h00, buf_irq_r};
            end else if (hit(reg_req.addr, `SISL_ADDR_IRQ_EN)) begin
                reg_rdata <= irq_en_r;
            end else if (hit(reg_req.addr, `SISL_ADDR_BUF_CTRL)) begin
                reg_rdata <= buf_ctrl_r;
            end else if (hit(reg_req.addr, `SISL_ADDR_BUF_THR)) begin
                reg_rdata <= buf_thr_r;
            end else if (hit(reg_req.addr, `SISL_ADDR_MODE_CTRL)) begin
                reg_rdata <= mode_ctrl_r;
            end else if (hit(reg_req.addr, `SISL_ADDR_PIN_CTRL)) begin
                reg_rdata <= pin_ctrl_r;
            end else begin
                // Unmapped and data addresses read as zero.
                reg_rdata <= `SISL_ZERO8;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks.
    ////////////////////////////////////////////////////////////////////////
    global_clear_a: assert property ((wr04 && !bitmask && sm_set == 6'h00 && !soft_reset_command)
        |=> sm_r == 6'h00) else $error("global clear left a flag");
    alias_ignored_a: assert property ((wr04 && bitmask && mode == SISL_MODE_LATCHED && !soft_reset_command)
        |=> sm_r == ($past(sm_r) | $past(sm_set))) else $error("alias cleared in bitmask mode");
    bitmask_sel_a: assert property ((wr14 && bitmask && mode == SISL_MODE_LATCHED && !soft_reset_command)
        |=> sm_r == (($past(sm_r) & ~$past(clr_sel)) | $past(sm_set))) else $error("bitmask clear wrong");
    buf_clear_a: assert property ((wr14 && bitmask && reg_req.wdata[`SISL_BUF_CLR_BIT] && buf_set == 3'h0)
        |=> buf_irq_r == 3'h0) else $error("buffer flags not cleared");
    buf_hold_a: assert property ((buf_any && !wr14 && !wr04 && !soft_reset_command)
        |=> buf_any) else $error("buffer flag lost without write");
    buf_gate_a: assert property ((reg_req.rd && hit(reg_req.addr, `SISL_ADDR_BUF_STAT) && !buf_en)
        |=> reg_rdata == 8'h00) else $error("buffer status shown while disabled");
    set_wins_a: assert property ((sm_set[5] && !soft_reset_command) |=> sm_r[5])
        else $error("sample event lost");
    temp_tmo_a: assert property ((tmo[5] && !sm_set[5]) |=> !sm_r[5])
        else $error("temporary latch did not expire");
    auto_z_a: assert property ((mode == SISL_MODE_AUTO && z_accum_start && !sm_set[5]) |=> !sm_r[5])
        else $error("sample flag survived accumulation");
    auto_motion_a: assert property ((mode == SISL_MODE_AUTO && !motion_cond[0] && !sm_set[0]) |=> !sm_r[0])
        else $error("motion flag outlived condition");
    route_default_a: assert property ((!swap && !merge && pin_ctrl_r[3:2] == 2'h3)
        |=> irq_pin_a.o == $past(sm_any)) else $error("pin a not following request a");
    route_swap_a: assert property ((swap && !merge && pin_ctrl_r[3:2] == 2'h3)
        |=> irq_pin_a.o == $past(buf_any)) else $error("swap did not move request b");
    merge_off_a: assert property ((merge && !swap && pin_ctrl_r[7:6] == 2'h3)
        |=> !irq_pin_b.o) else $error("request b active while merged");
    cover_temp_c: cover property (mode == SISL_MODE_TEMP && sm_r[5] ##1 !sm_r[5]);
    cover_full_c: cover property (buf_set[1]);
    cover_mask_c: cover property (bitmask && wr14 && sm_r != 6'h00);
endmodule
`default_nettype wire

// file: sisl_map.svh
`ifndef SISL_MAP_SVH
`define SISL_MAP_SVH
// Register offsets on the serial register port.
`define SISL_ADDR_CLR_ALIAS 8'h04
`define SISL_ADDR_IRQ_EN    8'h06
`define SISL_ADDR_BUF_STAT  8'h0A
`define SISL_ADDR_BUF_DATA  8'h0D
`define SISL_ADDR_IRQ_STAT  8'h14
`define SISL_ADDR_BUF_CTRL  8'h2D
`define SISL_ADDR_BUF_THR   8'h2E
`define SISL_ADDR_BUF_IRQ   8'h2F
`define SISL_ADDR_MODE_CTRL 8'h31
`define SISL_ADDR_PIN_CTRL  8'h33
// Field positions.
`define SISL_BUF_EMPTY_BIT  0
`define SISL_BUF_FULL_BIT   1
`define SISL_BUF_LEVEL_BIT  2
`define SISL_MERGE_BIT      3
`define SISL_BUF_EN_BIT     5
`define SISL_BUF_CLR_BIT    5
`define SISL_SAMPLE_BIT     7
`define SISL_SWAP_BIT       4
`define SISL_BITMASK_BIT    6
`define SISL_PIN_A_POL_BIT  2
`define SISL_PIN_A_PP_BIT   3
`define SISL_PIN_B_POL_BIT  6
`define SISL_PIN_B_PP_BIT   7
// Reset values and sizes.
`define SISL_ZERO8          8'h00
`define SISL_THR_RESET      8'h10
`define SISL_BUF_DEPTH      6'h20
// Temporary latch period in ns and the clock period in ns.
`define SISL_TEMP_LATCH_NS  2000000
`define SISL_CLK_NS         10
`endif

// file: sisl_pkg.sv
package sisl_pkg;
    // One register access, valid for one cycle.
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } sisl_reg_req_t;
    // Interrupt operating modes, Gray coded.
    typedef enum logic [1:0] {
        SISL_MODE_LATCHED = 2'h0,
        SISL_MODE_TEMP    = 2'h1,
        SISL_MODE_AUTO    = 2'h3
    } sisl_irq_mode_t;
    // Open-drain capable pin drive.
    typedef struct packed {
        logic o;
        logic oe;
    } sisl_pin_drv_t;
    // Buffer level conditions.
    typedef struct packed {
        logic level;
        logic full;
        logic empty;
    } sisl_buf_lvl_t;
endpackage
